// [verilog/drsc_top.v]
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "drsc_consts.vh"
module drsc_top #(
  parameter TICK_CYCLES = `DRSC_TICK_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire [28:0] status_cond_i,
  input  wire        bus_timeout_i,
  input  wire        pulse_ref_fast_i,
  input  wire        pulse_ref_slow_i,
  input  wire        pulse_fb_i,
  input  wire        trip_i,
  input  wire        manual_reset_i,
  input  wire        running_i,
  input  wire        start_cmd_i,
  input  wire        speed_below_fmax_i,
  input  wire        dc_brake_enabled_i,
  input  wire        closed_loop_i,
  input  wire        local_or_jog_i,
  input  wire [15:0] out_freq_i,
  input  wire [15:0] theo_freq_i,
  input  wire [15:0] ref_i,
  output wire        relay_one_o,
  output wire        relay_two_o,
  output wire        alt_motor_o,
  output wire        auto_reset_o,
  output wire        tripped_o,
  output wire        catch_spin_o,
  output wire        dc_brake_start_o,
  output wire        sleep_stop_o,
  output wire [15:0] ref_eff_o,
  output wire [15:0] pulse_ref_o,
  output wire [15:0] pulse_fb_o,
  output wire [15:0] level42_o,
  output wire [15:0] level45_o
);
  localparam ST_RUN  = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_HOLD = 2'd2;

  function [5:0] limit_of;
    input [3:0] mode;
    begin
      case (mode)
        4'd6:    limit_of = 6'd10;
        4'd7:    limit_of = 6'd15;
        4'd8:    limit_of = 6'd20;
        default: limit_of = {2'b00, mode};
      endcase
    end
  endfunction

  function [9:0] clip10;
    input [31:0] v;
    input [9:0]  mx;
    begin
      clip10 = (v[31:10] != 22'd0 || v[9:0] > mx) ? mx : v[9:0];
    end
  endfunction

  function [15:0] clipfs;
    input [15:0] v;
    input [15:0] mx;
    begin
      if (v < `DRSC_FS_MIN)
        clipfs = `DRSC_FS_MIN;
      else if (v > mx)
        clipfs = mx;
      else
        clipfs = v;
    end
  endfunction

  // configuration registers
  reg [4:0]  r1_sel_reg;
  reg [4:0]  r2_sel_reg;
  reg [9:0]  r1_on_reg;
  reg [9:0]  r1_off_reg;
  reg [15:0] cw_reg;
  reg [15:0] pref_fs_reg;
  reg        pref_slow_reg;
  reg [15:0] pfb_fs_reg;
  reg [9:0]  lvl42_reg;
  reg [9:0]  lvl45_reg;
  reg [3:0]  rmode_reg;
  reg [9:0]  rwait_reg;
  reg [1:0]  fly_reg;
  reg [8:0]  slp_time_reg;
  reg        slp_off_reg;
  reg [15:0] slp_freq_reg;
  reg [15:0] wake_freq_reg;
  reg [7:0]  boost_reg;
  reg [15:0] alt_per_reg;
  reg [31:0] prdata_reg;

  wire wr_en = psel_i & penable_i & pwrite_i;
  wire [31:0] d = pwdata_i;
  reg  mapped;
  reg  [31:0] rd_mux;

  // one second prescaler
  reg [31:0] pre_reg;
  wire tick = (pre_reg == TICK_CYCLES - 1);
  always @(posedge clk_i) begin
    if (rst_i || tick)
      pre_reg <= 32'h0000_0000;
    else
      pre_reg <= pre_reg + 32'h0000_0001;
  end

  // pulse pins: three-stage synchroniser plus agreement filter
  wire [2:0] pin_raw = {pulse_fb_i, pulse_ref_slow_i, pulse_ref_fast_i};
  wire [2:0] pin_edge;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      reg [2:0] s_reg;
      reg       lvl_reg;
      always @(posedge clk_i) begin
        if (rst_i) begin
          s_reg   <= 3'b000;
          lvl_reg <= 1'b0;
        end else begin
          s_reg <= {s_reg[1:0], pin_raw[g]};
          if (s_reg[1] == s_reg[2])
            lvl_reg <= s_reg[2];
        end
      end
      assign pin_edge[g] = (s_reg[1] == s_reg[2]) & s_reg[2] & ~lvl_reg;
    end
  endgenerate

  // apb register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      r1_sel_reg    <= `DRSC_R1_SEL_RST;
      r2_sel_reg    <= `DRSC_R2_SEL_RST;
      r1_on_reg     <= 10'd0;
      r1_off_reg    <= `DRSC_R1_OFF_RST;
      cw_reg        <= 16'h0000;
      pref_fs_reg   <= `DRSC_PREF_FS_RST;
      pref_slow_reg <= 1'b0;
      pfb_fs_reg    <= `DRSC_PFB_FS_RST;
      lvl42_reg     <= 10'd0;
      lvl45_reg     <= 10'd0;
      rmode_reg     <= `DRSC_RM_MANUAL;
      rwait_reg     <= `DRSC_RESTART_RST;
      fly_reg       <= 2'd0;
      slp_time_reg  <= 9'd0;
      slp_off_reg   <= 1'b1;
      slp_freq_reg  <= 16'h0000;
      wake_freq_reg <= `DRSC_WAKE_RST;
      boost_reg     <= `DRSC_BOOST_RST;
      alt_per_reg   <= `DRSC_ALT_RST;
    end else if (wr_en) begin
      case (paddr_i)
        `DRSC_RELAY_CFG: begin
          r1_sel_reg <= (d[4:0] > `DRSC_FN_ALTERNATE) ? 5'd0 : d[4:0];
          r2_sel_reg <= (d[12:8] > `DRSC_FN_ALTERNATE) ? 5'd0 : d[12:8];
        end
        `DRSC_R1_ON_DLY:  r1_on_reg <= clip10(d, `DRSC_DELAY_MAX);
        `DRSC_R1_OFF_DLY: r1_off_reg <= clip10(d, `DRSC_DELAY_MAX);
        `DRSC_CTRL_WORD:  cw_reg <= d[15:0];
        `DRSC_PREF_FS: begin
          pref_slow_reg <= d[16];
          pref_fs_reg   <= clipfs(d[15:0], d[16] ? `DRSC_FS_SLOW_MAX
                                                 : `DRSC_FS_FAST_MAX);
        end
        `DRSC_PFB_FS: pfb_fs_reg <= clipfs(d[15:0], `DRSC_FS_FAST_MAX);
        `DRSC_LEVEL42: lvl42_reg <= clip10(d, `DRSC_LEVEL_MAX);
        `DRSC_LEVEL45: lvl45_reg <= clip10(d, `DRSC_LEVEL_MAX);
        `DRSC_RESTART_CFG: begin
          rmode_reg <= (d[3:0] > `DRSC_RM_INFINITE) ? `DRSC_RM_INFINITE
                                                     : d[3:0];
          rwait_reg <= clip10({16'h0000, d[31:16]}, `DRSC_DELAY_MAX);
          fly_reg   <= d[9:8];
        end
        `DRSC_SLEEP_CFG: begin
          slp_off_reg  <= d[16];
          slp_time_reg <= (d[8:0] > `DRSC_SLEEP_MAX) ? `DRSC_SLEEP_MAX
                                                      : d[8:0];
        end
        `DRSC_SLEEP_FREQ: begin
          slp_freq_reg  <= d[15:0];
          wake_freq_reg <= d[31:16];
        end
        `DRSC_BOOST: begin
          if (d[7:0] < `DRSC_BOOST_MIN)
            boost_reg <= `DRSC_BOOST_MIN;
          else if (d[7:0] > `DRSC_BOOST_MAX)
            boost_reg <= `DRSC_BOOST_MAX;
          else
            boost_reg <= d[7:0];
        end
        `DRSC_ALT_PERIOD: alt_per_reg <= d[15:0];
        default: ;
      endcase
    end
  end

  // motor alternation timer
  reg [15:0] alt_cnt_reg;
  reg        alt_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      alt_cnt_reg <= 16'h0000;
      alt_reg     <= 1'b0;
    end else if (tick && alt_per_reg != 16'h0000) begin
      if (alt_cnt_reg >= alt_per_reg - 16'h0001) begin
        alt_cnt_reg <= 16'h0000;
        alt_reg     <= ~alt_reg;
      end else begin
        alt_cnt_reg <= alt_cnt_reg + 16'h0001;
      end
    end
  end

  function relay_req;
    input [4:0]  sel;
    input [28:0] cond;
    input        cw_bit;
    input        tmo;
    input        alt;
    begin
      if (sel == `DRSC_FN_CTRL_WORD)
        relay_req = cw_bit & ~tmo;
      else if (sel == `DRSC_FN_ALTERNATE)
        relay_req = alt;
      else if (sel == 5'd0)
        relay_req = 1'b0;
      else
        relay_req = cond[sel];
    end
  endfunction

  wire req1 = relay_req(r1_sel_reg, status_cond_i,
                        cw_reg[`DRSC_CW_RELAY1_BIT], bus_timeout_i, alt_reg);
  wire req2 = relay_req(r2_sel_reg, status_cond_i,
                        cw_reg[`DRSC_CW_RELAY2_BIT], bus_timeout_i, alt_reg);

  // relay one delays; the count restarts whenever the request changes
  reg       r1_reg;
  reg       r2_reg;
  reg       req1_q_reg;
  reg [9:0] r1_cnt_reg;
  wire [9:0] r1_dly = req1 ? r1_on_reg : r1_off_reg;
  // the free-running tick may come early, so wait one tick past the delay
  wire r1_done = (r1_dly == 10'd0) || (r1_cnt_reg > r1_dly);
  always @(posedge clk_i) begin
    if (rst_i) begin
      r1_reg     <= 1'b0;
      r2_reg     <= 1'b0;
      req1_q_reg <= 1'b0;
      r1_cnt_reg <= 10'd0;
    end else begin
      r2_reg     <= req2;
      req1_q_reg <= req1;
      if (req1 != req1_q_reg)
        r1_cnt_reg <= 10'd0;
      else if (req1 != r1_reg && tick)
        r1_cnt_reg <= r1_cnt_reg + 10'd1;
      // a drop forced by the bus timeout skips the turn-off delay
      if (r1_sel_reg == `DRSC_FN_CTRL_WORD && bus_timeout_i)
        r1_reg <= 1'b0;
      else if (req1 == req1_q_reg && req1 != r1_reg && r1_done)
        r1_reg <= req1;
    end
  end

  // automatic reset sequencer
  reg [1:0] rs_reg;
  reg [1:0] rs_next;
  reg [5:0] att_reg;
  reg [9:0] rwcnt_reg;
  reg [9:0] runok_reg;
  reg       ar_reg;
  wire can_retry = (rmode_reg == `DRSC_RM_INFINITE) ||
                   (att_reg < limit_of(rmode_reg));
  wire wait_done = (rwait_reg == 10'd0) || (rwcnt_reg > rwait_reg);
  always @* begin
    rs_next = rs_reg;
    case (rs_reg)
      ST_RUN:
        if (trip_i)
          rs_next = (rmode_reg != `DRSC_RM_MANUAL && can_retry) ?
                    ST_WAIT : ST_HOLD;
      ST_WAIT:
        if (manual_reset_i)
          rs_next = ST_RUN;
        else if (wait_done)
          rs_next = ST_RUN;
      ST_HOLD:
        if (manual_reset_i)
          rs_next = ST_RUN;
      default: rs_next = ST_RUN;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      rs_reg    <= ST_RUN;
      att_reg   <= 6'd0;
      rwcnt_reg <= 10'd0;
      runok_reg <= 10'd0;
      ar_reg    <= 1'b0;
    end else begin
      rs_reg <= rs_next;
      ar_reg <= (rs_reg == ST_WAIT) && !manual_reset_i &&
                wait_done;
      if (rs_reg != ST_WAIT)
        rwcnt_reg <= 10'd0;
      else if (tick)
        rwcnt_reg <= rwcnt_reg + 10'd1;
      if (!running_i || rs_reg != ST_RUN)
        runok_reg <= 10'd0;
      else if (tick && runok_reg < `DRSC_RUN_OK_SEC)
        runok_reg <= runok_reg + 10'd1;
      if (manual_reset_i || runok_reg >= `DRSC_RUN_OK_SEC)
        att_reg <= 6'd0;
      else if (rs_reg == ST_WAIT && rs_next == ST_RUN && att_reg != 6'd63)
        att_reg <= att_reg + 6'd1;
    end
  end

  // flying start
  wire dcb_sel = (fly_reg == `DRSC_FS_DCB_DESC) ||
                 (fly_reg == `DRSC_FS_DCB_LIST);
  reg catch_reg;
  reg dcb_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      catch_reg <= 1'b0;
      dcb_reg   <= 1'b0;
    end else begin
      catch_reg <= (fly_reg == `DRSC_FS_CATCH) && start_cmd_i &&
                   speed_below_fmax_i;
      dcb_reg   <= dcb_sel && start_cmd_i && dc_brake_enabled_i;
    end
  end

  // sleep mode
  reg        asleep_reg;
  reg [8:0]  slp_cnt_reg;
  reg [15:0] ref_eff_reg;
  wire slp_allow = !slp_off_reg && !local_or_jog_i;
  wire below = out_freq_i < slp_freq_reg;
  wire [23:0] boosted = ref_i * boost_reg / 24'd100;
  always @(posedge clk_i) begin
    if (rst_i) begin
      asleep_reg  <= 1'b0;
      slp_cnt_reg <= 9'd0;
      ref_eff_reg <= 16'h0000;
    end else begin
      if (!slp_allow || asleep_reg || !below)
        slp_cnt_reg <= 9'd0;
      else if (tick && slp_cnt_reg < slp_time_reg)
        slp_cnt_reg <= slp_cnt_reg + 9'd1;
      if (!slp_allow)
        asleep_reg <= 1'b0;
      else if (asleep_reg)
        asleep_reg <= !(theo_freq_i > wake_freq_reg);
      else if (below && slp_cnt_reg >= slp_time_reg)
        asleep_reg <= 1'b1;
      if (closed_loop_i && slp_allow && below && !asleep_reg)
        ref_eff_reg <= (boosted[23:16] != 8'h00) ? 16'hFFFF
                                                 : boosted[15:0];
      else
        ref_eff_reg <= ref_i;
    end
  end

  // pulse frequency measurement over a one second gate, then scaling
  reg [16:0] cnt_ref_reg;
  reg [16:0] cnt_fb_reg;
  reg [16:0] hz_ref_reg;
  reg [16:0] hz_fb_reg;
  wire ref_edge = pref_slow_reg ? pin_edge[1] : pin_edge[0];
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ref_reg <= 17'd0;
      cnt_fb_reg  <= 17'd0;
      hz_ref_reg  <= 17'd0;
      hz_fb_reg   <= 17'd0;
    end else if (tick) begin
      hz_ref_reg  <= cnt_ref_reg;
      hz_fb_reg   <= cnt_fb_reg;
      cnt_ref_reg <= {16'h0000, ref_edge};
      cnt_fb_reg  <= {16'h0000, pin_edge[2]};
    end else begin
      if (ref_edge && cnt_ref_reg != 17'h1FFFF)
        cnt_ref_reg <= cnt_ref_reg + 17'd1;
      if (pin_edge[2] && cnt_fb_reg != 17'h1FFFF)
        cnt_fb_reg <= cnt_fb_reg + 17'd1;
    end
  end

  // shared serial divider: ch0 reference, ch1 feedback
  reg        dv_ch_reg;
  reg        dv_busy_reg;
  reg [4:0]  dv_bit_reg;
  reg [31:0] dv_num_reg;
  reg [16:0] dv_rem_reg;
  reg [15:0] dv_den_reg;
  reg [15:0] pref_reg;
  reg [15:0] pfb_reg;
  wire [16:0] hz_sel = dv_ch_reg ? hz_fb_reg : hz_ref_reg;
  wire [15:0] fs_sel = dv_ch_reg ? pfb_fs_reg : pref_fs_reg;
  wire [15:0] hz_cl = (hz_sel >= {1'b0, fs_sel}) ? fs_sel : hz_sel[15:0];
  wire [17:0] dv_try = {dv_rem_reg, dv_num_reg[31]} - {2'b00, dv_den_reg};
  always @(posedge clk_i) begin
    if (rst_i) begin
      dv_ch_reg   <= 1'b0;
      dv_busy_reg <= 1'b0;
      dv_bit_reg  <= 5'd0;
      dv_num_reg  <= 32'h0000_0000;
      dv_rem_reg  <= 17'd0;
      dv_den_reg  <= 16'h0064;
      pref_reg    <= 16'h0000;
      pfb_reg     <= 16'h0000;
    end else if (!dv_busy_reg) begin
      dv_busy_reg <= 1'b1;
      dv_bit_reg  <= 5'd0;
      dv_rem_reg  <= 17'd0;
      dv_den_reg  <= fs_sel;
      dv_num_reg  <= {hz_cl, 16'h0000} - {16'h0000, hz_cl};
    end else begin
      if (dv_try[17]) begin
        dv_rem_reg <= {dv_rem_reg[15:0], dv_num_reg[31]};
        dv_num_reg <= {dv_num_reg[30:0], 1'b0};
      end else begin
        dv_rem_reg <= dv_try[16:0];
        dv_num_reg <= {dv_num_reg[30:0], 1'b1};
      end
      dv_bit_reg <= dv_bit_reg + 5'd1;
      if (dv_bit_reg == 5'd31) begin
        dv_busy_reg <= 1'b0;
        dv_ch_reg   <= ~dv_ch_reg;
        // last quotient bit joins the low bits already shifted in
        if (dv_ch_reg)
          pfb_reg <= {dv_num_reg[14:0], ~dv_try[17]};
        else
          pref_reg <= {dv_num_reg[14:0], ~dv_try[17]};
      end
    end
  end

  // level outputs scaled so 100.0 percent is full range
  reg [15:0] l42_reg;
  reg [15:0] l45_reg;
  wire [25:0] l42_w = lvl42_reg * 16'hFFFF / 26'd1000;
  wire [25:0] l45_w = lvl45_reg * 16'hFFFF / 26'd1000;
  always @(posedge clk_i) begin
    if (rst_i) begin
      l42_reg <= 16'h0000;
      l45_reg <= 16'h0000;
    end else begin
      l42_reg <= l42_w[15:0];
      l45_reg <= l45_w[15:0];
    end
  end

  // apb read mux, registered in the setup phase
  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `DRSC_RELAY_CFG:   rd_mux = {19'd0, r2_sel_reg, 3'd0, r1_sel_reg};
      `DRSC_R1_ON_DLY:   rd_mux = {22'd0, r1_on_reg};
      `DRSC_R1_OFF_DLY:  rd_mux = {22'd0, r1_off_reg};
      `DRSC_CTRL_WORD:   rd_mux = {16'd0, cw_reg};
      `DRSC_PREF_FS:     rd_mux = {15'd0, pref_slow_reg, pref_fs_reg};
      `DRSC_PFB_FS:      rd_mux = {16'd0, pfb_fs_reg};
      `DRSC_LEVEL42:     rd_mux = {22'd0, lvl42_reg};
      `DRSC_LEVEL45:     rd_mux = {22'd0, lvl45_reg};
      `DRSC_RESTART_CFG: rd_mux = {6'd0, rwait_reg, 6'd0, fly_reg,
                                   4'd0, rmode_reg};
      `DRSC_SLEEP_CFG:   rd_mux = {15'd0, slp_off_reg, 7'd0, slp_time_reg};
      `DRSC_SLEEP_FREQ:  rd_mux = {wake_freq_reg, slp_freq_reg};
      `DRSC_BOOST:       rd_mux = {24'd0, boost_reg};
      `DRSC_ALT_PERIOD:  rd_mux = {16'd0, alt_per_reg};
      `DRSC_STATUS:      rd_mux = {16'd0, att_reg, 1'b0, rs_reg, asleep_reg,
                                   dcb_reg, catch_reg, ar_reg, alt_reg,
                                   r2_reg, r1_reg};
      `DRSC_PULSE_OUT:   rd_mux = {pfb_reg, pref_reg};
      default:           mapped = 1'b0;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i)
      prdata_reg <= 32'h0000_0000;
    else if (psel_i && !penable_i)
      prdata_reg <= rd_mux;
  end

  assign prdata_o         = prdata_reg;
  assign pready_o         = 1'b1;
  assign pslverr_o        = psel_i & penable_i & ~mapped;
  assign relay_one_o      = r1_reg;
  assign relay_two_o      = r2_reg;
  assign alt_motor_o      = alt_reg;
  assign auto_reset_o     = ar_reg;
  assign tripped_o        = (rs_reg != ST_RUN);
  assign catch_spin_o     = catch_reg;
  assign dc_brake_start_o = dcb_reg;
  assign sleep_stop_o     = asleep_reg;
  assign ref_eff_o        = ref_eff_reg;
  assign pulse_ref_o      = pref_reg;
  assign pulse_fb_o       = pfb_reg;
  assign level42_o        = l42_reg;
  assign level45_o        = l45_reg;
endmodule

// [inc/drsc_consts.vh]
`ifndef DRSC_CONSTS_VH
`define DRSC_CONSTS_VH
// register byte offsets
`define DRSC_RELAY_CFG     8'h00
`define DRSC_R1_ON_DLY     8'h04
`define DRSC_R1_OFF_DLY    8'h08
`define DRSC_CTRL_WORD     8'h0C
`define DRSC_PREF_FS       8'h10
`define DRSC_PFB_FS        8'h14
`define DRSC_LEVEL42       8'h18
`define DRSC_LEVEL45       8'h1C
`define DRSC_RESTART_CFG   8'h20
`define DRSC_SLEEP_CFG     8'h24
`define DRSC_SLEEP_FREQ    8'h28
`define DRSC_BOOST         8'h2C
`define DRSC_ALT_PERIOD    8'h30
`define DRSC_STATUS        8'h34
`define DRSC_PULSE_OUT     8'h38
// relay function codes
`define DRSC_FN_CTRL_WORD  5'd29
`define DRSC_FN_ALTERNATE  5'd30
`define DRSC_CW_RELAY1_BIT 11
`define DRSC_CW_RELAY2_BIT 12
// reset values
`define DRSC_R1_SEL_RST    5'd10
`define DRSC_R2_SEL_RST    5'd3
`define DRSC_R1_OFF_RST    10'd2
`define DRSC_PREF_FS_RST   16'd5000
`define DRSC_PFB_FS_RST    16'd25000
`define DRSC_RESTART_RST   10'd10
`define DRSC_WAKE_RST      16'd500
`define DRSC_BOOST_RST     8'd100
`define DRSC_ALT_RST       16'd3600
// limits
`define DRSC_DELAY_MAX     10'd600
`define DRSC_SLEEP_MAX     9'd300
`define DRSC_FS_MIN        16'd100
`define DRSC_FS_FAST_MAX   16'd65000
`define DRSC_FS_SLOW_MAX   16'd5000
`define DRSC_LEVEL_MAX     10'd1000
`define DRSC_BOOST_MIN     8'd1
`define DRSC_BOOST_MAX     8'd200
`define DRSC_RUN_OK_SEC    10'd10
// reset mode codes
`define DRSC_RM_MANUAL     4'd0
`define DRSC_RM_INFINITE   4'd9
// flying start codes
`define DRSC_FS_CATCH      2'd1
`define DRSC_FS_DCB_DESC   2'd2
`define DRSC_FS_DCB_LIST   2'd3
// timing
`define DRSC_CLK_HZ        40000000
`define DRSC_TICK_SEC      1
`define DRSC_TICK_CYCLES   (`DRSC_CLK_HZ * `DRSC_TICK_SEC)
`endif

// [tb/drsc_stage.sv]
`timescale 1ns/1ps
module drsc_stage (
  input  wire  clk_i,
  input  wire  rst_i,
  input  wire  tripped_i,
  input  wire  sleep_i,
  output logic running_o = 1'b0
);
  // motor spins only while no trip holds and the drive is awake
  always @(posedge clk_i)
    running_o <= !rst_i && !tripped_i && !sleep_i;
endmodule

// [tb/drsc_top_chk.sv]
`timescale 1ns/1ps
module drsc_chk (
  input wire       clk_i,
  input wire       rst_i,
  input wire       psel_i,
  input wire       penable_i,
  input wire       pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire       bus_timeout_i,
  input wire       trip_i,
  input wire       manual_reset_i,
  input wire       start_cmd_i,
  input wire       speed_below_fmax_i,
  input wire       dc_brake_enabled_i,
  input wire       local_or_jog_i,
  input wire       relay_two_o,
  input wire       auto_reset_o,
  input wire       tripped_o,
  input wire       catch_spin_o,
  input wire       dc_brake_start_o,
  input wire       sleep_stop_o
);
  logic [4:0] sel_reg;
  logic       cw_reg;
  wire        wr = psel_i && penable_i && pwrite_i;
  // shadow of relay two source and control word bit 12
  always @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg <= 5'h3;
      cw_reg  <= 1'b0;
    end else if (wr && paddr_i == 8'h00)
      sel_reg <= (pwdata_i[12:8] > 5'd30) ? 5'h0 : pwdata_i[12:8];
    else if (wr && paddr_i == 8'h0C)
      cw_reg <= pwdata_i[12];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_cw;
    sel_reg == 5'd29 && $past(sel_reg) == 5'd29;
  endsequence
  sequence s_clear;
    manual_reset_i && !trip_i;
  endsequence
  property p_cw_on;
    s_cw and !$past(bus_timeout_i) |-> relay_two_o == $past(cw_reg);
  endproperty
  a_cw_on: assert property (p_cw_on) else $error("relay two bit");
  property p_cw_tmo;
    s_cw and $past(bus_timeout_i) |-> !relay_two_o;
  endproperty
  a_cw_tmo: assert property (p_cw_tmo) else $error("timeout");
  property p_ar_cause;
    auto_reset_o |-> $past(tripped_o);
  endproperty
  a_ar_cause: assert property (p_ar_cause) else $error("reset");
  property p_ar_pulse;
    auto_reset_o |=> !auto_reset_o [*2];
  endproperty
  a_ar_pulse: assert property (p_ar_pulse) else $error("pulse");
  property p_trip;
    trip_i && !tripped_o && !manual_reset_i |=> tripped_o;
  endproperty
  a_trip: assert property (p_trip) else $error("trip lost");
  property p_man;
    s_clear |=> !tripped_o;
  endproperty
  a_man: assert property (p_man) else $error("manual");
  property p_jog;
    local_or_jog_i |=> !sleep_stop_o;
  endproperty
  a_jog: assert property (p_jog) else $error("jog sleep");
  property p_dcb;
    dc_brake_start_o |-> $past(dc_brake_enabled_i && start_cmd_i);
  endproperty
  a_dcb: assert property (p_dcb) else $error("dc brake");
  property p_catch;
    catch_spin_o |-> $past(speed_below_fmax_i && start_cmd_i);
  endproperty
  a_catch: assert property (p_catch) else $error("catch");
endmodule

// [tb/drsc_top_test.sv]
`timescale 1ns/1ps
module drsc_top_test;
  logic        clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, bus_timeout_i = 1'b0, trip_i = 1'b0, er;
  logic        pulse_ref_fast_i = 1'b0, pulse_ref_slow_i = 1'b0;
  logic        pulse_fb_i = 1'b0, manual_reset_i = 1'b0, start_cmd_i = 1'b0;
  logic        speed_below_fmax_i = 1'b0, dc_brake_enabled_i = 1'b0;
  logic        closed_loop_i = 1'b0, local_or_jog_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [1:0]  ph = 2'd0;
  logic [28:0] status_cond_i = 29'h0;
  logic [15:0] out_freq_i = 16'h0, theo_freq_i = 16'h0, ref_i = 16'h0;
  logic [31:0] pwdata_i = 32'h0, rd, v, bg = 32'h847f_18c7;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, running_i, relay_one_o, relay_two_o;
  wire         alt_motor_o, auto_reset_o, tripped_o, catch_spin_o;
  wire         dc_brake_start_o, sleep_stop_o;
  wire  [15:0] ref_eff_o, pulse_ref_o, pulse_fb_o, level42_o, level45_o;
  int          errors = 0, total_checks = 0, n, c;
  function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function logic [31:0] lvl(input logic [31:0] x);
    return x * 65535 / 1000;
  endfunction
  drsc_top #(.TICK_CYCLES(20)) i_dut (.clk_i, .rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .status_cond_i, .bus_timeout_i, .pulse_ref_fast_i, .pulse_ref_slow_i,
    .pulse_fb_i, .trip_i, .manual_reset_i, .running_i, .start_cmd_i,
    .speed_below_fmax_i, .dc_brake_enabled_i, .closed_loop_i,
    .local_or_jog_i, .out_freq_i, .theo_freq_i, .ref_i, .relay_one_o,
    .relay_two_o, .alt_motor_o, .auto_reset_o, .tripped_o, .catch_spin_o,
    .dc_brake_start_o, .sleep_stop_o, .ref_eff_o, .pulse_ref_o,
    .pulse_fb_o, .level42_o, .level45_o);
  drsc_stage i_stage (.clk_i, .rst_i, .tripped_i(tripped_o),
    .sleep_i(sleep_stop_o), .running_o(running_i));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    bg <= xs(bg);
    ph <= ph + 2'd1;
    // fast reference and feedback pins get a four-cycle square wave: five edges a gate
    {pulse_ref_fast_i, pulse_ref_slow_i} <= {ph[1], bg[2]};
    {pulse_fb_i, start_cmd_i} <= {ph[1], bg[0]};
    {speed_below_fmax_i, dc_brake_enabled_i, closed_loop_i} <= bg[6:4];
    ref_i <= bg[31:16];
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (pready_o !== 1'b1)
      errors++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task pulse_trip;
    @(posedge clk_i);
    trip_i <= 1'b1;
    @(posedge clk_i);
    trip_i <= 1'b0;
  endtask
  initial begin
    cyc(10);
    rst_i <= 1'b0;
    apb(0, 8'h00, 0);
    chk(rd, 32'h0000_030A);
    apb(0, 8'h04, 0);
    chk(rd, 32'h0);
    apb(0, 8'h24, 0);
    chk(rd, 32'h0001_0000);
    apb(0, 8'h3C, 0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1, 8'h18, 32'h0000_07D0);
    apb(0, 8'h18, 0);
    chk(rd, 32'h0000_03E8);
    v = bg % 1001;
    apb(1, 8'h1C, v);
    cyc(2);
    chk(level45_o, lvl(v));
    chk(level42_o, lvl(1000));
    apb(1, 8'h04, 0);
    apb(1, 8'h08, 0);
    apb(1, 8'h00, 32'h0000_1D1D);
    repeat (3) begin
      v = bg;
      apb(1, 8'h0C, v);
      cyc(4);
      chk({relay_two_o, relay_one_o}, v[12:11]);
    end
    bus_timeout_i <= 1'b1;
    apb(1, 8'h0C, 32'h0000_1800);
    cyc(4);
    chk({relay_two_o, relay_one_o}, 2'b00);
    bus_timeout_i <= 1'b0;
    repeat (4) begin
      c = 1 + bg % 28;
      apb(1, 8'h00, (c << 8) | 5);
      status_cond_i <= bg[28:0];
      cyc(4);
      chk(relay_two_o, status_cond_i[c]);
    end
    apb(1, 8'h30, 2);
    apb(1, 8'h00, 32'h0000_1E05);
    repeat (2) begin
      v = alt_motor_o;
      n = 0;
      while (alt_motor_o === v[0] && n < 100) begin
        @(posedge clk_i);
        n++;
      end
    end
    chk(n, 40);
    chk(relay_two_o, v[0]);
    apb(1, 8'h04, 2);
    apb(1, 8'h08, 2);
    status_cond_i <= 29'h0;
    cyc(100);
    for (int b = 1; b >= 0; b--) begin
      status_cond_i[5] <= b[0];
      cyc(30);
      chk(relay_one_o, !b[0]);
      cyc(35);
      chk(relay_one_o, b[0]);
    end
    apb(1, 8'h20, 32'h0001_0001);
    pulse_trip;
    @(posedge clk_i);
    chk(tripped_o, 1'b1);
    n = 0;
    while (auto_reset_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= 17 && n < 60, 1'b1);
    pulse_trip;
    cyc(80);
    chk(tripped_o, 1'b1);
    manual_reset_i <= 1'b1;
    cyc(1);
    manual_reset_i <= 1'b0;
    cyc(3);
    chk(tripped_o, 1'b0);
    apb(1, 8'h28, 32'h01F4_00C8);
    out_freq_i <= 16'd100;
    apb(1, 8'h24, 1);
    cyc(70);
    chk(sleep_stop_o, 1'b1);
    theo_freq_i <= 16'd600;
    cyc(5);
    chk(sleep_stop_o, 1'b0);
    theo_freq_i <= 16'd0;
    cyc(70);
    local_or_jog_i <= 1'b1;
    cyc(3);
    chk(sleep_stop_o, 1'b0);
    apb(1, 8'h24, 300);
    apb(1, 8'h2C, 125);
    local_or_jog_i <= 1'b0;
    cyc(1);
    repeat (8) begin
      v = closed_loop_i ? ref_i * 125 / 100 : ref_i;
      @(posedge clk_i);
      chk(ref_eff_o, (v > 32'h0000_FFFF) ? 32'h0000_FFFF : v);
    end
    for (c = 1; c < 4; c++) begin
      apb(1, 8'h20, c << 8);
      cyc(1);
      repeat (8) begin
        v = {start_cmd_i && speed_below_fmax_i && c == 1,
             start_cmd_i && dc_brake_enabled_i && c > 1};
        @(posedge clk_i);
        chk({catch_spin_o, dc_brake_start_o}, v);
      end
    end
    apb(1, 8'h10, 50);
    apb(1, 8'h14, 100);
    cyc(200);
    chk(pulse_ref_o, 5 * 65535 / 100);
    chk(pulse_fb_o, 5 * 65535 / 100);
    finish_test;
  end
  initial begin
    #500000;
    errors++;
    finish_test;
  end
endmodule
bind drsc_top drsc_chk i_chk (.clk_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .bus_timeout_i, .trip_i, .manual_reset_i,
  .start_cmd_i, .speed_below_fmax_i, .dc_brake_enabled_i, .local_or_jog_i,
  .relay_two_o, .auto_reset_o, .tripped_o, .catch_spin_o, .dc_brake_start_o,
  .sleep_stop_o);
